// ==== scs_osc_model.sv ====
// Behavioural oscillators facing the clock switch
module scs_osc_model #(
  parameter int EXT_HALF = 40,
  parameter int SOSC_HALF = 50,
  parameter int LF_HALF = 20,
  parameter int INT_HALF = 40,
  parameter int READY_NS = 2000
) (
  input wire logic ext_run, // Primary crystal alive
  input wire logic sosc_run, // Secondary enabled
  output logic ext_clk_in, // Primary pin
  output logic sosc_clk_in, // Secondary pin
  output logic lfint_clk_in, // Low-frequency internal
  output logic int_clk_in, // Internal block
  output logic sosc_ready_in // Secondary ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // A dead crystal freezes at its last level
  initial begin
    ext_clk_in = 1'b0;
    forever begin
      #(EXT_HALF);
      if (ext_run) ext_clk_in = ~ext_clk_in;
    end
  end
  // Secondary stands still while disabled
  initial begin
    sosc_clk_in = 1'b0;
    forever begin
      #(SOSC_HALF);
      if (sosc_run) sosc_clk_in = ~sosc_clk_in;
    end
  end
  // Internal oscillators run free
  initial begin
    lfint_clk_in = 1'b0;
    forever #(LF_HALF) lfint_clk_in = ~lfint_clk_in;
  end
  initial begin
    int_clk_in = 1'b0;
    forever #(INT_HALF) int_clk_in = ~int_clk_in;
  end
  // Ready only after a warm-up, so early selection would be seen
  initial begin
    sosc_ready_in = 1'b0;
    forever begin
      @(sosc_run);
      sosc_ready_in = 1'b0;
      if (sosc_run) #(READY_NS) sosc_ready_in = sosc_run;
    end
  end
endmodule

// ==== scs_pkg.sv ====
// Constants and types shared by the clock switch and fail-safe monitor
package scs_pkg;
  // System clock select field encodings
  localparam logic [1:0] SCS_CONFIG = 2'h0;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;
  localparam int SCS_INTERNAL_BIT = 1;
  localparam logic [1:0] SCS_RESET = 2'h0;

  // Internal frequency select reset value (500 kHz)
  localparam logic [3:0] IFS_RESET = 4'h7;

  // Oscillator configuration encodings
  localparam logic [2:0] OSC_LOW_POWER_CRYSTAL = 3'h0;
  localparam logic [2:0] OSC_CRYSTAL = 3'h1;
  localparam logic [2:0] OSC_HIGH_SPEED_CRYSTAL = 3'h2;
  localparam logic [2:0] OSC_EXTERNAL_CLOCK = 3'h3;
  localparam logic [2:0] OSC_INTERNAL_BLOCK = 3'h4;

  // Start-up and monitor counts
  localparam int STARTUP_WIDTH = 11;
  localparam logic [10:0] STARTUP_COUNT = 11'h400;
  localparam logic [1:0] EXT_DELAY_COUNT = 2'h2;
  localparam int SAMPLE_DIV = 64;
  localparam logic [4:0] SAMPLE_HALF_LAST = 5'h1f;

  // Time figures and their cycle counts at sys_clk
  localparam int CLK_PERIOD_NS = 10;
  localparam int HF_WARM_NS = 2000;
  localparam int HF_WARM_CYC = (HF_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_NS = 2000000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_WIDTH = 8;
  localparam int PLL_WIDTH = 18;

  // Synchroniser lane positions
  localparam int LANE_EXT = 0;
  localparam int LANE_SOSC = 1;
  localparam int LANE_LFINT = 2;
  localparam int LANE_INT = 3;
  localparam int LANE_SOSC_RDY = 4;
  localparam int LANES = 5;

  typedef enum logic [1:0] {SRC_LOW, SRC_INT, SRC_EXT, SRC_SOSC} scs_src_t;

  typedef enum logic [3:0] {
    ST_POR, ST_SLEEP, ST_STARTUP, ST_EXT_WAIT, ST_INT_FALL, ST_HOLD, ST_EXT, ST_INT, ST_FAIL
  } scs_state_t;
endpackage

// ==== scs_switch.sv ====
// System clock source switch with two-speed start-up and fail-safe monitor
// Functional notes
// - Select 00 runs from the source chosen by the oscillator configuration
// - Select 01 runs CPU and peripherals from the secondary oscillator
// - Select 1x runs from internal block; every reset clears the select field
// - Automatic switches never alter the select field; status bit shows source
// - Status reads 1 on configured external source after start-up, 0 internal
// - Crystal modes count 1024 oscillator cycles before that source is used
// - Two-speed start-up is off for any non-crystal configuration
// - Two-speed needs switchover bit, select 00, crystal; starts at reset or wake
// - Enabling the fail-safe monitor also forces two-speed start-up on
// - Timer reaching 1024 awake sets status and moves execution to external
// - Sleep during start-up aborts the timer and leaves status clear
// - Switchover: expiry, internal fall, set status, hold low, external fall
// - Settle delays: external clock 2 cycles, internal 2 us, PLL ready 2 ms; secondary has none
// - Sample clock is the low-frequency internal oscillator divided by 64
// - Latch set on external fall, cleared on sample rise; fail if never set
// - On failure switch to internal source and set the oscillator fail flag
// - After failure stay on internal until firmware switches back
// - Reset, sleep or select change clear fail; select change restarts timer
// - Software clears the fail flag; it stays clear on internal until external runs and fails again
// - Monitoring starts after timer expiry, or after the 2-cycle settle in external clock modes
// - Every reset loads internal frequency select with 0111
module scs_switch
  import scs_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ext_clk_in, // Primary external oscillator
  input wire logic sosc_clk_in, // Secondary oscillator
  input wire logic lfint_clk_in, // Low-frequency internal oscillator
  input wire logic int_clk_in, // Internal block at selected frequency
  input wire logic sosc_ready_in, // Secondary oscillator ready level
  input wire logic [2:0] osc_config_select, // Oscillator configuration
  input wire logic two_speed_enable, // Switchover configuration bit
  input wire logic fail_safe_enable, // Fail-safe monitor configuration bit
  input wire logic powerup_done, // Power-up delay expired, level
  input wire logic sleep_req, // Sleep instruction pulse
  input wire logic wake_req, // Wake-up pulse
  input wire logic scs_wr, // Select field write strobe
  input wire logic [1:0] scs_wdata, // Select field write data
  input wire logic ifs_wr, // Frequency select write strobe
  input wire logic [3:0] ifs_wdata, // Frequency select write data
  input wire logic osc_fail_clr, // Fail flag clear strobe
  input wire logic osc_fail_irq_enable, // Fail interrupt enable
  input wire logic pll_enable, // PLL enable level
  output logic [1:0] sys_clock_select, // Select field
  output logic [3:0] internal_freq_select, // Frequency select field
  output logic startup_timer_status, // Running from configured source
  output logic secondary_osc_ready, // Secondary oscillator ready
  output logic osc_fail_flag, // Sticky oscillator fail flag
  output logic osc_fail_irq, // Fail interrupt request
  output logic fail_safe_active, // Running on internal after failure
  output logic pll_ready, // PLL settled
  output logic [1:0] clk_source, // Source now on the system clock
  output logic sys_clk_out // Switched system clock
);
  logic [LANES-1:0] pin_level, pin_rise, pin_fall;

  scs_sync #(.WIDTH(LANES)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({sosc_ready_in, int_clk_in, lfint_clk_in, sosc_clk_in, ext_clk_in}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic ext_fall, int_fall;
  assign ext_fall = pin_fall[LANE_EXT];
  assign int_fall = pin_fall[LANE_INT];

  // Register-side fields
  logic [1:0] scs_q, scs_d;
  logic [3:0] ifs_q, ifs_d;
  logic scs_change;
  assign scs_change = scs_wr && (scs_wdata != scs_q);

  always_comb begin
    scs_d = scs_wr ? scs_wdata : scs_q;
    ifs_d = ifs_wr ? ifs_wdata : ifs_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scs_q <= SCS_RESET;
      ifs_q <= IFS_RESET;
    end else begin
      scs_q <= scs_d;
      ifs_q <= ifs_d;
    end
  end

  // Configuration decode
  logic is_crystal, is_internal_cfg, two_speed_on;
  assign is_crystal = (osc_config_select == OSC_LOW_POWER_CRYSTAL) ||
                      (osc_config_select == OSC_CRYSTAL) ||
                      (osc_config_select == OSC_HIGH_SPEED_CRYSTAL);
  assign is_internal_cfg = (osc_config_select == OSC_INTERNAL_BLOCK);
  // Fail-safe forces two-speed; crystal and select 00 are required
  assign two_speed_on = (two_speed_enable || fail_safe_enable) && is_crystal &&
                        (scs_q == SCS_CONFIG);

  // Crystal modes count first; external clock only settles briefly
  scs_state_t start_st;
  assign start_st = is_crystal ? ST_STARTUP :
                    is_internal_cfg ? ST_INT : ST_EXT_WAIT;
  // Source sequencer
  scs_state_t state_q, state_d;
  logic [STARTUP_WIDTH-1:0] tmr_q, tmr_d;
  logic status_q, status_d;
  logic fail_det, mux_low;

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    status_d = status_q;
    if (sleep_req && state_q != ST_POR) begin
      state_d = ST_SLEEP;
      tmr_d = '0;
      status_d = 1'b0;
    end else if (scs_change && state_q != ST_POR && state_q != ST_SLEEP) begin
      state_d = start_st;
      tmr_d = '0;
      status_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_POR, ST_SLEEP: begin
          if ((state_q == ST_POR) ? powerup_done : wake_req) begin
            state_d = start_st;
          end
        end
        ST_STARTUP: begin
          if (ext_fall) begin
            tmr_d = tmr_q + 1'b1;
            if (tmr_q == STARTUP_COUNT - 1'b1) begin
              // Without two-speed the core is halted, so no internal edge to wait on
              state_d = two_speed_on ? ST_INT_FALL : ST_HOLD;
              status_d = !two_speed_on && (scs_q == SCS_CONFIG);
            end
          end
        end
        ST_EXT_WAIT: begin
          if (ext_fall) begin
            tmr_d = tmr_q + 1'b1;
            if (tmr_q[1:0] == EXT_DELAY_COUNT - 1'b1) begin
              state_d = ST_EXT;
              status_d = (scs_q == SCS_CONFIG);
            end
          end
        end
        ST_INT_FALL: begin
          if (int_fall) begin
            state_d = ST_HOLD;
            status_d = 1'b1;
          end
        end
        ST_HOLD: begin
          if (mux_low) begin
            state_d = ST_EXT;
          end
        end
        ST_EXT: begin
          if (fail_det) begin
            state_d = ST_FAIL;
            status_d = 1'b0;
          end
        end
        ST_INT, ST_FAIL: status_d = 1'b0;
        default: begin
          state_d = ST_POR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= ST_POR;
      tmr_q <= '0;
      status_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      status_q <= status_d;
    end
  end

  // Fail-safe detector: sample clock from slow internal oscillator
  logic [4:0] div_q, div_d;
  logic smp_q, smp_d;
  logic latch_q, latch_d;
  logic arm, smp_toggle;
  assign arm = fail_safe_enable && state_q == ST_EXT && scs_q == SCS_CONFIG;
  assign smp_toggle = pin_rise[LANE_LFINT] && (div_q == SAMPLE_HALF_LAST);
  // Judged at the end of the high half, after a full half-cycle without a set
  assign fail_det = arm && smp_toggle && smp_q && !latch_q && !ext_fall;

  always_comb begin
    div_d = pin_rise[LANE_LFINT] ? div_q + 1'b1 : div_q;
    smp_d = smp_toggle ? !smp_q : smp_q;
    latch_d = latch_q;
    if (!arm || ext_fall) begin
      latch_d = 1'b1;
    end else if (smp_toggle && !smp_q) begin
      latch_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_q <= '0;
      smp_q <= 1'b0;
      latch_q <= 1'b1;
    end else begin
      div_q <= div_d;
      smp_q <= smp_d;
      latch_q <= latch_d;
    end
  end

  // Fail flag: a new failure beats a clear in the same cycle
  logic flag_q, flag_d, irq_q, irq_d;
  always_comb begin
    flag_d = fail_det || (flag_q && !osc_fail_clr);
    irq_d = flag_d && osc_fail_irq_enable;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  // Target source: low in power-up wait or sleep, then select field, then sequencer state
  scs_src_t tgt;
  always_comb begin
    if (state_q == ST_POR || state_q == ST_SLEEP) begin
      tgt = SRC_LOW;
    end else if (scs_q[SCS_INTERNAL_BIT]) begin
      tgt = SRC_INT;
    end else if (scs_q == SCS_SECONDARY) begin
      tgt = SRC_SOSC;
    end else begin
      unique case (state_q)
        ST_STARTUP: tgt = two_speed_on ? SRC_INT : SRC_LOW;
        ST_INT_FALL, ST_INT, ST_FAIL: tgt = SRC_INT;
        ST_EXT: tgt = SRC_EXT;
        default: tgt = SRC_LOW;
      endcase
    end
  end

  // Glitch-free mux: park low on old source's low phase, join new at its fall
  scs_src_t cur_q, cur_d;
  logic [WARM_WIDTH-1:0] warm_q, warm_d;
  logic out_q, out_d;
  logic warm_done;
  logic [3:0] src_fall;
  logic [3:0] src_level;
  assign src_fall = {pin_fall[LANE_SOSC], pin_fall[LANE_EXT], int_fall, 1'b0};
  assign src_level = {pin_level[LANE_SOSC], pin_level[LANE_EXT], pin_level[LANE_INT], 1'b0};
  assign warm_done = (warm_q == WARM_WIDTH'(HF_WARM_CYC));
  assign mux_low = (cur_q == SRC_LOW);

  always_comb begin
    cur_d = cur_q;
    warm_d = '0;
    if (tgt == SRC_INT && cur_q != SRC_INT) begin
      warm_d = warm_done ? warm_q : warm_q + 1'b1;
    end
    if (tgt != cur_q) begin
      if (cur_q != SRC_LOW) begin
        // A dead source may freeze high; its long high phase makes parking safe
        if (!src_level[cur_q] || state_q == ST_FAIL) begin
          cur_d = SRC_LOW;
        end
      end else if (tgt != SRC_LOW && src_fall[tgt] && (tgt != SRC_INT || warm_done)) begin
        cur_d = tgt;
      end
    end
    out_d = (cur_q == SRC_LOW) ? 1'b0 : src_level[cur_q];
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cur_q <= SRC_LOW;
      warm_q <= '0;
      out_q <= 1'b0;
    end else begin
      cur_q <= cur_d;
      warm_q <= warm_d;
      out_q <= out_d;
    end
  end

  // PLL settle timer; long count shortened through the parameter
  logic [PLL_WIDTH-1:0] pll_q, pll_d;
  logic pll_rdy_q, pll_rdy_d;
  always_comb begin
    pll_d = '0;
    if (pll_enable) begin
      pll_d = pll_rdy_q ? pll_q : pll_q + 1'b1;
    end
    pll_rdy_d = pll_enable && (pll_d == PLL_WIDTH'(PLL_LOCK_CYCLES));
  end

  // Status outputs registered
  logic sosc_rdy_q, fsafe_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pll_q <= '0;
      pll_rdy_q <= 1'b0;
      sosc_rdy_q <= 1'b0;
      fsafe_q <= 1'b0;
    end else begin
      pll_q <= pll_d;
      pll_rdy_q <= pll_rdy_d;
      sosc_rdy_q <= pin_level[LANE_SOSC_RDY];
      fsafe_q <= (state_d == ST_FAIL);
    end
  end

  assign sys_clock_select = scs_q;
  assign internal_freq_select = ifs_q;
  assign startup_timer_status = status_q;
  assign secondary_osc_ready = sosc_rdy_q;
  assign osc_fail_flag = flag_q;
  assign osc_fail_irq = irq_q;
  assign fail_safe_active = fsafe_q;
  assign pll_ready = pll_rdy_q;
  assign clk_source = cur_q;
  assign sys_clk_out = out_q;
endmodule

// ==== scs_switch_chk.sv ====
// Port assertions for the clock switch and fail-safe monitor
module scs_switch_chk
  import scs_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic powerup_done, // Power-up over
  input wire logic sleep_req, // Sleep pulse
  input wire logic scs_wr, // Select write
  input wire logic [1:0] scs_wdata, // Select data
  input wire logic osc_fail_clr, // Flag clear
  input wire logic osc_fail_irq_enable, // Irq enable
  input wire logic [1:0] sys_clock_select, // Select field
  input wire logic [3:0] internal_freq_select, // Frequency field
  input wire logic startup_timer_status, // Status bit
  input wire logic secondary_osc_ready, // Secondary ready
  input wire logic osc_fail_flag, // Fail flag
  input wire logic osc_fail_irq, // Fail irq
  input wire logic fail_safe_active, // Fail state
  input wire logic [1:0] clk_source, // Current source
  input wire logic sys_clk_out // Switched clock
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Requests that open a multi-step switch
  sequence s_sec_req;
    scs_wr && scs_wdata == SCS_SECONDARY && secondary_osc_ready;
  endsequence
  sequence s_int_req;
    scs_wr && scs_wdata[SCS_INTERNAL_BIT];
  endsequence
  sequence s_fail_hit;
    $rose(fail_safe_active);
  endsequence

  // Field values right after reset
  property p_reset;
    $rose(reset_n) |-> sys_clock_select == SCS_RESET && internal_freq_select == IFS_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("fields not at reset value");
  property p_kept;
    !scs_wr |=> $stable(sys_clock_select);
  endproperty
  a_kept: assert property (p_kept) else $error("select moved without write");
  // Failure: flag and status at once, internal source soon after
  property p_fail_entry;
    s_fail_hit |-> osc_fail_flag && !startup_timer_status ##[1:700] clk_source == SRC_INT;
  endproperty
  a_fail_entry: assert property (p_fail_entry) else $error("failure entry wrong");
  property p_irq;
    osc_fail_irq == (osc_fail_flag && $past(osc_fail_irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not flag and enable");
  property p_fail_status;
    fail_safe_active |-> !startup_timer_status;
  endproperty
  a_fail_status: assert property (p_fail_status) else $error("status high on fail");
  property p_sticky;
    osc_fail_flag && !osc_fail_clr |=> osc_fail_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fail flag dropped");
  property p_sec;
    s_sec_req |-> ##[1:200] clk_source == SRC_SOSC;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary not joined");
  property p_int;
    s_int_req |-> ##[1:700] clk_source == SRC_INT;
  endproperty
  a_int: assert property (p_int) else $error("internal not joined");
  // Status rise is followed closely by the external source
  property p_expiry;
    $rose(startup_timer_status) |-> ##[0:40] clk_source == SRC_EXT;
  endproperty
  a_expiry: assert property (p_expiry) else $error("external not joined");
  property p_sleep;
    sleep_req && powerup_done && !startup_timer_status |=> !startup_timer_status [*8];
  endproperty
  a_sleep: assert property (p_sleep) else $error("status set after sleep");
  // Sources are all at least four cycles per half period
  property p_glitch;
    $changed(sys_clk_out) |=> $stable(sys_clk_out) [*2];
  endproperty
  a_glitch: assert property (p_glitch) else $error("short clock pulse");
endmodule

bind scs_switch scs_switch_chk u_chk (
  .sys_clk, .reset_n, .powerup_done, .sleep_req, .scs_wr, .scs_wdata, .osc_fail_clr,
  .osc_fail_irq_enable, .sys_clock_select, .internal_freq_select, .startup_timer_status,
  .secondary_osc_ready, .osc_fail_flag, .osc_fail_irq, .fail_safe_active, .clk_source,
  .sys_clk_out
);

// ==== scs_switch_tb.sv ====
// Self-checking bench for the clock switch and fail-safe monitor
module scs_switch_tb
  import scs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, reset_n, ext_clk_in, sosc_clk_in, lfint_clk_in, int_clk_in, sosc_ready_in;
  logic [2:0] osc_config_select;
  logic two_speed_enable, fail_safe_enable, powerup_done, sleep_req, wake_req, scs_wr;
  logic [1:0] scs_wdata, sys_clock_select, clk_source;
  logic ifs_wr, osc_fail_clr, osc_fail_irq_enable, pll_enable, ext_run, sosc_run;
  logic [3:0] ifs_wdata, internal_freq_select;
  logic startup_timer_status, secondary_osc_ready, osc_fail_flag, osc_fail_irq;
  logic fail_safe_active, pll_ready, sys_clk_out;
  int errors, compares;

  // Short PLL lock keeps the run brief
  scs_switch #(.PLL_LOCK_CYCLES(20)) dut (
    .sys_clk, .reset_n, .ext_clk_in, .sosc_clk_in, .lfint_clk_in, .int_clk_in, .sosc_ready_in,
    .osc_config_select, .two_speed_enable, .fail_safe_enable, .powerup_done, .sleep_req,
    .wake_req, .scs_wr, .scs_wdata, .ifs_wr, .ifs_wdata, .osc_fail_clr, .osc_fail_irq_enable,
    .pll_enable, .sys_clock_select, .internal_freq_select, .startup_timer_status,
    .secondary_osc_ready, .osc_fail_flag, .osc_fail_irq, .fail_safe_active, .pll_ready,
    .clk_source, .sys_clk_out
  );
  scs_osc_model osc (
    .ext_run, .sosc_run, .ext_clk_in, .sosc_clk_in, .lfint_clk_in, .int_clk_in, .sosc_ready_in
  );

  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic tick(int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic chk(string name, logic [3:0] exp, logic [3:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded waits; running out counts as a mismatch
  task automatic wait_hi(const ref logic sig, input int lim, input string name);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk(name, 4'h1, 4'(sig));
    if (n >= lim) results();
  endtask
  task automatic wait_src(logic [1:0] src, int lim);
    int n;
    n = 0;
    while (clk_source !== src && n < lim) begin
      tick(1);
      n++;
    end
    chk("clk_source", 4'(src), 4'(clk_source));
    if (n >= lim) results();
  endtask
  // Switched clock must follow the joined source; 16 cycles span two periods
  task automatic chk_clk_out(int exp_rises);
    int n;
    logic prev;
    n = 0;
    prev = sys_clk_out;
    repeat (16) begin
      tick(1);
      if (sys_clk_out === 1'b1 && prev === 1'b0) n++;
      prev = sys_clk_out;
    end
    chk("sys_clk_out rises", 4'(exp_rises), 4'(n));
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  task automatic write_scs(logic [1:0] v);
    scs_wdata = v;
    pulse(scs_wr);
  endtask
  task automatic do_reset(logic [2:0] cfg, logic ts, logic fs);
    reset_n = 1'b0;
    powerup_done = 1'b0;
    osc_config_select = cfg;
    two_speed_enable = ts;
    fail_safe_enable = fs;
    tick(5);
    reset_n = 1'b1;
    tick(1);
    powerup_done = 1'b1;
  endtask

  // Crystal start-up, two-speed forced by the monitor enable
  task automatic t_startup();
    do_reset(OSC_CRYSTAL, 1'b0, 1'b1);
    chk("sys_clock_select", 4'(SCS_RESET), 4'(sys_clock_select));
    chk("internal_freq_select", IFS_RESET, internal_freq_select);
    wait_src(SRC_INT, 600);
    tick(3000);
    chk("startup_timer_status", 4'h0, 4'(startup_timer_status));
    wait_src(SRC_EXT, 7000);
    chk("startup_timer_status", 4'h1, 4'(startup_timer_status));
    chk("sys_clock_select", 4'h0, 4'(sys_clock_select));
    chk_clk_out(2);
    $display("startup test done");
  endtask
  // Crystal dies, flag and fallback, then a software restart
  task automatic t_fail();
    osc_fail_irq_enable = 1'b1;
    ext_run = 1'b0;
    wait_hi(osc_fail_flag, 800, "osc_fail_flag");
    chk("fail_safe_active", 4'h1, 4'(fail_safe_active));
    chk("startup_timer_status", 4'h0, 4'(startup_timer_status));
    chk("sys_clock_select", 4'h0, 4'(sys_clock_select));
    tick(1);
    chk("osc_fail_irq", 4'h1, 4'(osc_fail_irq));
    wait_src(SRC_INT, 700);
    pulse(osc_fail_clr);
    chk("osc_fail_flag", 4'h0, 4'(osc_fail_flag));
    tick(1000);
    chk("clk_source", 4'(SRC_INT), 4'(clk_source));
    ext_run = 1'b1;
    write_scs(2'h2);
    write_scs(2'h0);
    wait_src(SRC_INT, 600);
    wait_src(SRC_EXT, 9500);
    chk("fail_safe_active", 4'h0, 4'(fail_safe_active));
    $display("fail test done");
  endtask
  // Sleep aborts start-up; wake restarts it
  task automatic t_sleep();
    do_reset(OSC_CRYSTAL, 1'b1, 1'b0);
    tick(2000);
    pulse(sleep_req);
    tick(9000);
    chk("startup_timer_status", 4'h0, 4'(startup_timer_status));
    chk_clk_out(0);
    pulse(wake_req);
    wait_src(SRC_INT, 600);
    wait_src(SRC_EXT, 9500);
    $display("sleep test done");
  endtask
  // Software selection of secondary and internal, frequency and PLL
  task automatic t_select();
    sosc_run = 1'b1;
    wait_hi(secondary_osc_ready, 1000, "secondary_osc_ready");
    write_scs(2'h1);
    wait_src(SRC_SOSC, 200);
    write_scs(2'h3);
    wait_src(SRC_INT, 700);
    chk("sys_clock_select", 4'h3, 4'(sys_clock_select));
    ifs_wdata = 4'hf;
    pulse(ifs_wr);
    chk("internal_freq_select", 4'hf, internal_freq_select);
    pll_enable = 1'b1;
    tick(5);
    chk("pll_ready", 4'h0, 4'(pll_ready));
    wait_hi(pll_ready, 100, "pll_ready");
    pll_enable = 1'b0;
    $display("select test done");
  endtask
  // External clock mode needs no timer; internal mode runs internal
  task automatic t_modes();
    do_reset(OSC_EXTERNAL_CLOCK, 1'b0, 1'b1);
    wait_src(SRC_EXT, 100);
    chk("startup_timer_status", 4'h1, 4'(startup_timer_status));
    ext_run = 1'b0;
    wait_hi(osc_fail_flag, 800, "osc_fail_flag");
    ext_run = 1'b1;
    do_reset(OSC_INTERNAL_BLOCK, 1'b0, 1'b0);
    wait_src(SRC_INT, 600);
    chk("startup_timer_status", 4'h0, 4'(startup_timer_status));
    chk_clk_out(2);
    $display("modes test done");
  endtask

  // Main sequence
  initial begin
    errors = 0;
    compares = 0;
    {reset_n, powerup_done, sleep_req, wake_req, scs_wr, scs_wdata, ifs_wr, ifs_wdata} = '0;
    {osc_config_select, two_speed_enable, fail_safe_enable, osc_fail_clr} = '0;
    {osc_fail_irq_enable, pll_enable, sosc_run} = '0;
    ext_run = 1'b1;
    t_startup();
    t_fail();
    t_sleep();
    t_select();
    t_modes();
    results();
  end
endmodule

// ==== scs_sync.sv ====
// Two-flop synchroniser with edge pulses for a group of pin inputs
module scs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Inputs from other domains
  output logic [WIDTH-1:0] level, // Synchronised level
  output logic [WIDTH-1:0] rise, // One-cycle rising pulse
  output logic [WIDTH-1:0] fall // One-cycle falling pulse
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // First stage feeds only the second; edges compare stages two and three
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule
